// ===== uep_pkg.sv
package uep_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EP0_IN_CFG = 8'h04;
  localparam logic [7:0] ADDR_EP0_OUT_CFG = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODULE_EN_POS = 0;
  localparam int CFG_ENDPOINT_EN_POS = 7;
  localparam int STAT_SETUP_POS = 0;
  localparam int STAT_BABBLE_POS = 1;
  localparam int STAT_ORPHAN_POS = 2;
  localparam int STATUS_HOLD_POS = 3;
  localparam int STATUS_TX_POS = 4;
  localparam int STAT_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_RST = 1'b0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [2:0] INT_STAT_RST = 3'h0;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_TIME_NS = 83;
  localparam int BIT_CYC_RAW = (BIT_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int BIT_CYC = (BIT_CYC_RAW < 1) ? 1 : BIT_CYC_RAW;
  localparam int BABBLE_LIMIT_CYC = 2048;

  // ----------------------------------------------------------------
  // Link types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    uep_pid_setup,
    uep_pid_in,
    uep_pid_out,
    uep_pid_sof
  } uep_pid_t;

  typedef enum logic {
    uep_hs_ack,
    uep_hs_nak
  } uep_hs_t;

  typedef struct packed {
    logic valid;
    uep_pid_t pid;
    logic [3:0] ep;
  } uep_tok_t;

  typedef struct packed {
    logic valid;
    uep_hs_t pid;
  } uep_hs_out_t;

endpackage

// ===== uep_watchdog.sv
`timescale 1ns/1ns
`default_nettype none

// Counts cycles while run is high; expired once limit is reached
module uep_watchdog #(
  parameter int LIMIT = 4,
  parameter int W = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic clr,
  input wire logic run,
  // Status
  output logic expired
);

  logic [W-1:0] count;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= '0;
    end
    else if (clr || !run)
    begin
      count <= '0;
    end
    else if (count != W'(LIMIT))
    begin
      count <= count + W'(1);
    end
  end

  assign expired = (count == W'(LIMIT));

endmodule

`default_nettype wire

// ===== uep_ep0_setup.sv
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module uep_ep0_setup #(
  parameter int BABBLE_LIMIT = uep_pkg::BABBLE_LIMIT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Token side of the serial engine
  input wire uep_pkg::uep_tok_t rx_tok,
  input wire logic rx_busy,
  input wire logic tx_active,
  input wire logic tx_done,
  // Response side of the serial engine
  output uep_pkg::uep_hs_out_t hs_out,
  output logic tx_start,
  output logic tx_abort,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    uep_st_idle,
    uep_st_data,
    uep_st_wait
  } uep_state_t;

  uep_state_t state;
  logic module_en;
  logic [7:0] ep0_in_config_reg;
  logic [7:0] ep0_out_config_reg;
  logic [2:0] usb_interrupt_flag_reg;
  logic [2:0] int_mask;
  logic nak_hold;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_pend;
  logic [7:0] rd_addr;
  logic addr_ok;
  logic [2:0] next_stat;
  logic [2:0] stat_set;
  logic [2:0] stat_clr;
  logic ep_in_en;
  logic ep_out_en;
  logic both_en;
  logic gated;
  logic ep0_tok;
  logic idle_ok;
  logic babble;
  logic [31:0] rd_mux;
  logic setup_flag;

  assign setup_flag = usb_interrupt_flag_reg[uep_pkg::STAT_SETUP_POS];
  assign ep_in_en = ep0_in_config_reg[uep_pkg::CFG_ENDPOINT_EN_POS];
  assign ep_out_en = ep0_out_config_reg[uep_pkg::CFG_ENDPOINT_EN_POS];
  assign both_en = ep_in_en && ep_out_en;
  assign gated = !ep_in_en && !ep_out_en;
  assign ep0_tok = rx_tok.valid && (rx_tok.ep == 4'h0) && module_en;

  // ----------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok && hwrite)
      begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so data comes straight from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_pend <= 1'b0;
      rd_addr <= 8'h00;
      hreadyout <= 1'b1;
    end
    else
    begin
      rd_pend <= addr_ok && !hwrite;
      hreadyout <= !(addr_ok && !hwrite);
      if (addr_ok && !hwrite)
      begin
        rd_addr <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      uep_pkg::ADDR_CTRL:
      begin
        rd_mux[uep_pkg::CTRL_MODULE_EN_POS] = module_en;
      end
      uep_pkg::ADDR_EP0_IN_CFG:
      begin
        rd_mux[7:0] = ep0_in_config_reg;
      end
      uep_pkg::ADDR_EP0_OUT_CFG:
      begin
        rd_mux[7:0] = ep0_out_config_reg;
      end
      uep_pkg::ADDR_INT_STAT:
      begin
        rd_mux[2:0] = usb_interrupt_flag_reg;
      end
      uep_pkg::ADDR_INT_MASK:
      begin
        rd_mux[2:0] = int_mask;
      end
      uep_pkg::ADDR_STATUS:
      begin
        rd_mux[2:0] = usb_interrupt_flag_reg;
        rd_mux[uep_pkg::STATUS_HOLD_POS] = nak_hold;
        rd_mux[uep_pkg::STATUS_TX_POS] = (state != uep_st_idle);
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend)
    begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      module_en <= uep_pkg::CTRL_RST;
    end
    else if (wr_pend && wr_addr == uep_pkg::ADDR_CTRL)
    begin
      module_en <= hwdata[uep_pkg::CTRL_MODULE_EN_POS];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ep0_in_config_reg <= uep_pkg::CFG_RST;
      ep0_out_config_reg <= uep_pkg::CFG_RST;
      int_mask <= uep_pkg::INT_MASK_RST;
    end
    else if (!module_en)
    begin
      ep0_in_config_reg <= uep_pkg::CFG_RST;
      ep0_out_config_reg <= uep_pkg::CFG_RST;
      if (wr_pend && wr_addr == uep_pkg::ADDR_INT_MASK)
      begin
        int_mask <= hwdata[2:0];
      end
    end
    else if (wr_pend)
    begin
      if (wr_addr == uep_pkg::ADDR_EP0_IN_CFG)
      begin
        ep0_in_config_reg <= hwdata[7:0];
      end
      if (wr_addr == uep_pkg::ADDR_EP0_OUT_CFG)
      begin
        ep0_out_config_reg <= hwdata[7:0];
      end
      if (wr_addr == uep_pkg::ADDR_INT_MASK)
      begin
        int_mask <= hwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_comb
  begin
    stat_set = 3'h0;
    stat_set[uep_pkg::STAT_SETUP_POS] =
      ep0_tok && rx_tok.pid == uep_pkg::uep_pid_setup;
    stat_set[uep_pkg::STAT_BABBLE_POS] = babble;
    stat_set[uep_pkg::STAT_ORPHAN_POS] = ep0_tok && !both_en;
    stat_clr = 3'h0;
    if (wr_pend && wr_addr == uep_pkg::ADDR_INT_STAT)
    begin
      stat_clr = hwdata[2:0];
    end
    next_stat = (usb_interrupt_flag_reg & ~stat_clr) | stat_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      usb_interrupt_flag_reg <= uep_pkg::INT_STAT_RST;
    end
    else if (!module_en)
    begin
      usb_interrupt_flag_reg <= uep_pkg::INT_STAT_RST;
    end
    else
    begin
      usb_interrupt_flag_reg <= next_stat;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(next_stat & int_mask) && module_en;
    end
  end

  // ----------------------------------------------------------------
  // Engine's own copy of the flag
  // ----------------------------------------------------------------
  // While either endpoint is enabled, a clear reaches the engine only after the link has been quiet for
  // one bit time, so it can never land inside a token's CRC bits.
  uep_watchdog #(
    .LIMIT(uep_pkg::BIT_CYC),
    .W(4)
  ) u_idle_guard (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(rx_tok.valid),
    .run(!rx_busy && module_en),
    .expired(idle_ok)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nak_hold <= 1'b0;
    end
    else if (!module_en)
    begin
      nak_hold <= 1'b0;
    end
    else if (stat_set[uep_pkg::STAT_SETUP_POS])
    begin
      nak_hold <= 1'b1;
    end
    else if (gated || (idle_ok && state == uep_st_idle))
    begin
      nak_hold <= setup_flag;
    end
  end

  // ----------------------------------------------------------------
  // Babble watchdog
  // ----------------------------------------------------------------
  // Only a safety net: correct operation never relies on it.
  uep_watchdog #(
    .LIMIT(BABBLE_LIMIT),
    .W(16)
  ) u_babble (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(!module_en),
    .run(tx_active),
    .expired(babble)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_abort <= 1'b0;
    end
    else
    begin
      tx_abort <= (babble || !module_en) && tx_active;
    end
  end

  // ----------------------------------------------------------------
  // Token handling
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= uep_st_idle;
      hs_out <= '0;
      tx_start <= 1'b0;
    end
    else if (!module_en)
    begin
      state <= uep_st_idle;
      hs_out <= '0;
      tx_start <= 1'b0;
    end
    else
    begin
      hs_out <= '0;
      tx_start <= 1'b0;
      case (state)
        uep_st_idle:
        begin
          if (ep0_tok && both_en)
          begin
            if (rx_tok.pid == uep_pkg::uep_pid_setup)
            begin
              hs_out.valid <= 1'b1;
              hs_out.pid <= uep_pkg::uep_hs_ack;
            end
            else if (rx_tok.pid == uep_pkg::uep_pid_in)
            begin
              if (nak_hold || setup_flag)
              begin
                hs_out.valid <= 1'b1;
                hs_out.pid <= uep_pkg::uep_hs_nak;
              end
              else
              begin
                tx_start <= 1'b1;
                state <= uep_st_data;
              end
            end
          end
        end
        uep_st_data:
        begin
          if (tx_active)
          begin
            state <= uep_st_wait;
          end
          else if (tx_done)
          begin
            state <= uep_st_idle;
          end
        end
        uep_st_wait:
        begin
          if (tx_done || babble || !tx_active)
          begin
            state <= uep_st_idle;
          end
        end
        default:
        begin
          state <= uep_st_idle;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== uep_ep0_setup_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module uep_ep0_setup_properties #(
  parameter int BABBLE_LIMIT = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Link
  input wire uep_pkg::uep_tok_t rx_tok,
  input wire logic tx_active,
  input wire uep_pkg::uep_hs_out_t hs_out,
  input wire logic tx_start,
  input wire logic tx_abort
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ep0;
  logic acc;
  int run_cnt;
  assign ep0 = rx_tok.valid && rx_tok.ep == 4'h0;
  assign acc = hsel && hready && htrans[1];
  // Length of the current transmit burst
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      run_cnt <= 0;
    else
      run_cnt <= tx_active ? run_cnt + 1 : 0;
  property p_ack;
    hs_out.valid && hs_out.pid == uep_pkg::uep_hs_ack
      |-> $past(ep0 && rx_tok.pid == uep_pkg::uep_pid_setup);
  endproperty
  a_ack: assert property (p_ack) else $error("ack without setup");
  property p_nak;
    hs_out.valid && hs_out.pid == uep_pkg::uep_hs_nak
      |-> $past(ep0 && rx_tok.pid == uep_pkg::uep_pid_in);
  endproperty
  a_nak: assert property (p_nak) else $error("nak without in");
  property p_start;
    tx_start |-> !hs_out.valid
      && $past(ep0 && rx_tok.pid == uep_pkg::uep_pid_in);
  endproperty
  a_start: assert property (p_start) else $error("stray start");
  property p_silent;
    ep0 && rx_tok.pid inside {uep_pkg::uep_pid_out, uep_pkg::uep_pid_sof}
      |=> !hs_out.valid && !tx_start;
  endproperty
  a_silent: assert property (p_silent) else $error("answer to out");
  property p_bound;
    run_cnt > BABBLE_LIMIT + 4 |-> tx_abort;
  endproperty
  a_bound: assert property (p_bound) else $error("endless tx");
  property p_abort;
    $rose(tx_abort) |-> $past(tx_active);
  endproperty
  a_abort: assert property (p_abort) else $error("abort while idle");
  property p_rd;
    acc && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait state");
  property p_wr;
    acc && hwrite |=> hreadyout [*2];
  endproperty
  a_wr: assert property (p_wr) else $error("write wait state");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
endmodule
bind uep_ep0_setup uep_ep0_setup_properties #(.BABBLE_LIMIT(BABBLE_LIMIT))
  u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .rx_tok, .tx_active, .hs_out, .tx_start, .tx_abort);
`default_nettype wire

// ===== uep_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host and serial engine model
// ------------------------------------------------------------
module uep_host_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Mode: never end a transmit by itself
  input wire logic hang,
  // Device answers
  input wire uep_pkg::uep_hs_out_t hs_out,
  input wire logic tx_start,
  input wire logic tx_abort,
  // Link to device
  output var uep_pkg::uep_tok_t rx_tok,
  output logic rx_busy,
  output logic tx_active,
  output logic tx_done
);
  int n_ack, n_nak, n_start, left;
  initial
  begin
    rx_tok = '0;
    rx_busy = 1'b0;
  end
  // Busy for three cycles, then a one-cycle token
  task automatic send_tok(input uep_pkg::uep_pid_t pid);
    rx_busy <= 1'b1;
    repeat (3) @(posedge hclk);
    rx_tok <= '{1'b1, pid, 4'h0};
    rx_busy <= 1'b0;
    @(posedge hclk);
    // Released lines show the inverse, not the last value
    rx_tok <= '{1'b0, uep_pkg::uep_pid_t'(~pid), 4'hf};
  endtask
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_active <= 1'b0;
      tx_done <= 1'b0;
      n_ack <= 0;
      n_nak <= 0;
      n_start <= 0;
      left <= 0;
    end
    else
    begin
      tx_done <= 1'b0;
      n_ack <= n_ack
        + int'(hs_out.valid && hs_out.pid == uep_pkg::uep_hs_ack);
      n_nak <= n_nak
        + int'(hs_out.valid && hs_out.pid == uep_pkg::uep_hs_nak);
      if (tx_start)
      begin
        n_start <= n_start + 1;
        tx_active <= 1'b1;
        left <= 4;
      end
      else if (tx_active && tx_abort)
        tx_active <= 1'b0;
      else if (tx_active && !hang && left == 0)
      begin
        tx_active <= 1'b0;
        tx_done <= 1'b1;
      end
      else if (left > 0)
        left <= left - 1;
    end
endmodule
`default_nettype wire

// ===== usb_ep0_setup_handling_bench.sv
`timescale 1ns/1ns
`default_nettype none
module usb_ep0_setup_handling_bench;
  localparam int BL = 20;
  logic hclk, hresetn, hsel, hwrite, hang, hreadyout, hresp, irq;
  logic rx_busy, tx_active, tx_done, tx_start, tx_abort;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  uep_pkg::uep_tok_t rx_tok;
  uep_pkg::uep_hs_out_t hs_out;
  int err_total, tests_run, k, d, s;
  uep_ep0_setup #(.BABBLE_LIMIT(BL)) dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .rx_tok, .rx_busy, .tx_active, .tx_done,
    .hs_out, .tx_start, .tx_abort, .irq);
  uep_host_model host (.hclk, .hresetn, .hang, .hs_out, .tx_start,
    .tx_abort, .rx_tok, .rx_busy, .tx_active, .tx_done);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task end_sim;
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  function automatic logic exp_irq(input logic [2:0] st, input logic [2:0] mk);
    return |(st & mk);
  endfunction
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    ahb(1'b1, a, wd);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string m);
    ahb(1'b0, a, 32'h0);
    chk(r, e, m);
  endtask
  task tok(input uep_pkg::uep_pid_t p, input int n);
    host.send_tok(p);
    repeat (n) @(posedge hclk);
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog, tests
  // ------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    #2000000;
    err_total++;
    end_sim();
  end
  initial
  begin
    {hresetn, hsel, hwrite, hang, htrans, haddr, hwdata} = '0;
    s = $urandom(32'h112a3665);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(uep_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
    rd(uep_pkg::ADDR_INT_MASK, 32'h0, "mask reset");
    rd(8'h40, 32'h0, "unmapped");
    wr(uep_pkg::ADDR_CTRL, 32'h1);
    k = $urandom_range(127, 0);
    wr(uep_pkg::ADDR_EP0_IN_CFG, 32'h80 | k);
    rd(uep_pkg::ADDR_EP0_IN_CFG, 32'h80 | k, "cfg");
    wr(uep_pkg::ADDR_EP0_OUT_CFG, 32'h80);
    wr(uep_pkg::ADDR_INT_MASK, 32'h7);
    tok(uep_pkg::uep_pid_setup, 2);
    chk(host.n_ack, 1, "ack");
    chk(irq, exp_irq(3'h1, 3'h7), "irq set");
    rd(uep_pkg::ADDR_INT_STAT, 32'h1, "flag");
    k = $urandom_range(4, 1);
    repeat (k) tok(uep_pkg::uep_pid_in, 2);
    chk(host.n_nak, k, "naks");
    tok(uep_pkg::uep_pid_out, 2);
    chk(host.n_start + host.n_ack, 1, "out");
    wr(uep_pkg::ADDR_INT_MASK, 32'h0);
    // Irq is registered: the mask is already taken when wr returns, one edge shows it
    repeat (2) @(posedge hclk);
    chk(irq, exp_irq(3'h1, 3'h0), "masked");
    wr(uep_pkg::ADDR_INT_MASK, 32'h1);
    // Clear lands at each of five cycles, from the second busy cycle of an incoming token to two cycles after the token
    for (d = 0; d < 5; d++)
    begin
      fork
        host.send_tok(uep_pkg::uep_pid_in);
        begin
          repeat (d) @(posedge hclk);
          wr(uep_pkg::ADDR_INT_STAT, 32'h1);
        end
      join
      repeat (15) @(posedge hclk);
      s = host.n_start;
      tok(uep_pkg::uep_pid_in, 3);
      chk(host.n_start, s + 1, "data");
      repeat (10) @(posedge hclk);
      chk(tx_active, 1'b0, "babble");
      tok(uep_pkg::uep_pid_setup, 2);
    end
    rd(uep_pkg::ADDR_STATUS, 32'h9, "status");
    wr(uep_pkg::ADDR_EP0_IN_CFG, 32'h0);
    wr(uep_pkg::ADDR_EP0_OUT_CFG, 32'h0);
    s = host.n_nak + host.n_start;
    tok(uep_pkg::uep_pid_in, 2);
    chk(host.n_nak + host.n_start, s, "gated");
    rd(uep_pkg::ADDR_INT_STAT, 32'h5, "orphan");
    wr(uep_pkg::ADDR_INT_STAT, 32'h5);
    wr(uep_pkg::ADDR_EP0_IN_CFG, 32'h80);
    wr(uep_pkg::ADDR_EP0_OUT_CFG, 32'h80);
    s = host.n_start;
    tok(uep_pkg::uep_pid_in, 3);
    chk(host.n_start, s + 1, "resume");
    // Far side keeps sending until the device aborts
    repeat (10) @(posedge hclk);
    hang <= 1'b1;
    tok(uep_pkg::uep_pid_in, BL + 12);
    chk(host.n_start, s + 2, "hang start");
    chk(tx_active, 1'b0, "abort");
    rd(uep_pkg::ADDR_INT_STAT, 32'h2, "babble flag");
    hang <= 1'b0;
    wr(uep_pkg::ADDR_CTRL, 32'h0);
    rd(uep_pkg::ADDR_INT_STAT, 32'h0, "soft reset");
    rd(uep_pkg::ADDR_EP0_IN_CFG, 32'h0, "cfg cleared");
    wr(uep_pkg::ADDR_CTRL, 32'h1);
    rd(uep_pkg::ADDR_STATUS, 32'h0, "idle");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(uep_pkg::ADDR_CTRL, 32'h0, "hard reset");
    end_sim();
  end
endmodule
`default_nettype wire
